// [src/uwk_defines.vh]
// Register offsets, field positions, reset values and codes for the wake controller.
// Assumes inclusion by the wake control module and the testbench.
`ifndef UWK_DEFINES_VH
`define UWK_DEFINES_VH
// ==================================================
// Register byte offsets (APB, one word each)
`define UWK_HARDWARE_CONFIG_REG_OFS 12'h000
`define UWK_IRQ_STS_OFS 12'h004
`define UWK_POWER_CONTROL_REG_OFS 12'h008
`define UWK_PIN_CFG_A_OFS 12'h00C
`define UWK_PIN_CFG_B_OFS 12'h010
`define UWK_PIN_WAKE_OFS 12'h014
`define UWK_WAKE_CAUSE_OFS 12'h018
`define UWK_WAKE_CTRL_STATUS_REG_ONE_OFS 12'h01C
`define UWK_STATE_OFS 12'h020
// ==================================================
// Hardware configuration fields
`define UWK_HW_DETACH_EN_BIT 0
`define UWK_HW_DETACH_RET_BIT 1
// Interrupt status fields: pin bits 11:0, phy flag 12
`define UWK_IRQ_PHY_BIT 12
// Power control fields
`define UWK_PMT_WUPS0_BIT 0
`define UWK_PMT_WUPS1_BIT 1
`define UWK_PMT_PHY_WAKE_EN_BIT 2
`define UWK_PMT_LAN_WAKE_EN_BIT 3
`define UWK_PMT_SUSP_LO 4
`define UWK_PMT_SUSP_HI 5
`define UWK_PMT_PME_MODE_BIT 6
`define UWK_PMT_SUSP_PIN_BIT 7
// Pin wake register: enables 11:0, polarity 27:16
`define UWK_PIN_POL_LO 16
// Control/status register one fields
`define UWK_WU_EXACT_BIT 0
`define UWK_WU_BCAST_BIT 1
`define UWK_WU_GOOD_BIT 2
`define UWK_WU_EEE_RX_BIT 3
`define UWK_WU_EEE_TX_BIT 4
// Wake cause bits 11:0 pins, then these
`define UWK_WC_PHY_BIT 12
`define UWK_WC_MAGIC_BIT 13
`define UWK_WC_FRAME_BIT 14
`define UWK_WC_BCAST_BIT 15
`define UWK_WC_EXACT_BIT 16
`define UWK_WC_SYN_BIT 17
`define UWK_WC_EEE_RX_BIT 18
`define UWK_WC_EEE_TX_BIT 19
`define UWK_WC_GOOD_BIT 20
`define UWK_WC_RESUME_BIT 21
// Suspend level codes
`define UWK_SUSP_SHALLOW 2'h0
`define UWK_SUSP_DEEP 2'h2
`define UWK_SUSP_ALWAYS_ON 2'h3
`define UWK_SUSP_RESET 2'h2
// Power states
`define UWK_ST_UNPOWERED 3'h0
`define UWK_ST_UNCONF 3'h1
`define UWK_ST_CONF 3'h2
`define UWK_ST_SUSPEND 3'h3
`define UWK_ST_DETACHED 3'h4
`define UWK_ST_PLL_UP 3'h5
`endif

// [src/uwk_wake_ctrl.v]
// Power-state and wake-event control for a USB to Ethernet bridge.
// Assumes wake detectors and USB controller events on I_CLK; pins arrive async.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "uwk_defines.vh"

module uwk_wake_ctrl #(
  parameter NPIN = 12,
  parameter PLL_LOCK_CYCLES = 16
) (
  input wire I_CLK,
  input wire I_SRST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  input wire [NPIN-1:0] I_GPIO,
  input wire I_BUS_POWER_SENSE,
  input wire I_USB_RESET,
  input wire I_USB_SUSPEND,
  input wire I_USB_RESUME,
  input wire I_USB_SET_CONFIG,
  input wire I_USB_CLR_CONFIG,
  input wire I_REMOTE_WAKE_FEATURE,
  input wire I_USB_HS_FS,
  input wire I_PHY_IRQ,
  input wire I_LINK_UP,
  input wire I_MAC_WAKE,
  input wire I_MAGIC_PKT,
  input wire I_WAKE_FRAME,
  input wire I_BCAST_FRAME,
  input wire I_EXACT_FRAME,
  input wire I_TCP_SYN,
  input wire I_EEE_RX_WAKE,
  input wire I_EEE_TX_WAKE,
  input wire I_GOOD_FRAME,
  output reg O_USB_ATTACH,
  output reg O_PLL_EN,
  output reg O_AFE_EN,
  output reg O_REMOTE_WAKE,
  output reg O_SUSPEND_N,
  output reg O_PHY_IRQ_EP,
  output reg O_PME
);

  // ==================================================
  // Sources and permission helpers
  localparam NSRC = 10;
  // Source index: 0 phy,1 magic,2 frame,3 bcast,4 exact,5 syn,6 eeerx,7 eeetx,8 good,9 pin
  function [NSRC-1:0] permit;
    input [2:0] st;
    input [1:0] lvl;
    input pme;
    begin
      permit = {NSRC{1'b0}};
      if (st == `UWK_ST_DETACHED) begin
        permit = 10'h201;
      end else if (st == `UWK_ST_SUSPEND) begin
        if (pme) begin
          permit = 10'h21F;
        end else if (lvl == `UWK_SUSP_ALWAYS_ON) begin
          permit = 10'h3FF;
        end else if (lvl == `UWK_SUSP_DEEP) begin
          permit = 10'h200;
        end else begin
          permit = 10'h2FF;
        end
      end
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a[11:2] == ofs[11:2]);
    end
  endfunction

  // ==================================================
  // Pin and bus-power synchronisers
  reg [NPIN-1:0] pin_s1_q;
  reg [NPIN-1:0] pin_s2_q;
  reg vb_s1_q;
  reg vb_s2_q;
  always @(posedge I_CLK) begin
    pin_s1_q <= I_GPIO;
    pin_s2_q <= pin_s1_q;
    vb_s1_q <= I_BUS_POWER_SENSE;
    vb_s2_q <= vb_s1_q;
  end

  // ==================================================
  // Registers
  reg detach_en_q;
  reg detach_ret_q;
  reg [NPIN:0] irq_q;
  reg wups0_q;
  reg wups1_q;
  reg phy_wake_en_q;
  reg lan_wake_en_q;
  reg [1:0] susp_lvl_q;
  reg pme_mode_q;
  reg susp_pin_q;
  reg [NPIN-1:0] pin_en_a_q;
  reg [NPIN-1:0] pin_en_b_q;
  reg [NPIN-1:0] pin_wake_en_q;
  reg [NPIN-1:0] pin_pol_q;
  reg [21:0] cause_q;
  reg [4:0] wucsr_q;
  reg [2:0] state_q;
  reg [7:0] lock_cnt_q;

  wire wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  wire wr_hw = wr & hit(I_PADDR, `UWK_HARDWARE_CONFIG_REG_OFS);
  wire wr_irq = wr & hit(I_PADDR, `UWK_IRQ_STS_OFS);
  wire wr_pmt = wr & hit(I_PADDR, `UWK_POWER_CONTROL_REG_OFS);
  wire wr_wc = wr & hit(I_PADDR, `UWK_WAKE_CAUSE_OFS);

  // Pin wake: synced level vs polarity, gated by the wake enable and either config enable
  wire [NPIN-1:0] pin_act = ~(pin_s2_q ^ pin_pol_q) & pin_wake_en_q
                            & (pin_en_a_q | pin_en_b_q);
  wire pin_any = |pin_act;

  // Per-source live events; bcast, exact, EEE and good sources have their enable bits folded in
  wire [NSRC-1:0] src = {pin_any,
                         I_GOOD_FRAME & wucsr_q[`UWK_WU_GOOD_BIT],
                         I_EEE_TX_WAKE & wucsr_q[`UWK_WU_EEE_TX_BIT],
                         I_EEE_RX_WAKE & wucsr_q[`UWK_WU_EEE_RX_BIT],
                         I_TCP_SYN,
                         I_EXACT_FRAME & wucsr_q[`UWK_WU_EXACT_BIT],
                         I_BCAST_FRAME & wucsr_q[`UWK_WU_BCAST_BIT],
                         I_WAKE_FRAME,
                         I_MAGIC_PKT,
                         I_PHY_IRQ};
  wire [NSRC-1:0] ok = permit(state_q, susp_lvl_q, pme_mode_q);
  // Status ANDed with enable and state permission; pins are their own status
  wire wake_req = (wups0_q & phy_wake_en_q & ok[0])
                | (wups1_q & lan_wake_en_q & |ok[8:1])
                | (pin_any & ok[9]);
  wire detach_link_wake = (state_q == `UWK_ST_DETACHED) & I_LINK_UP;
  wire host_resume = I_USB_RESUME & (state_q == `UWK_ST_SUSPEND);

  // ==================================================
  // Power state machine
  reg configured_q;
  always @(posedge I_CLK) begin
    if (I_SRST || I_USB_RESET) begin
      state_q <= `UWK_ST_UNPOWERED;
      configured_q <= 1'b0;
      lock_cnt_q <= 8'h00;
      O_REMOTE_WAKE <= 1'b0;
    end else begin
      O_REMOTE_WAKE <= 1'b0;
      case (state_q)
        `UWK_ST_UNPOWERED: begin
          if (vb_s2_q) begin
            state_q <= `UWK_ST_UNCONF;
          end
        end
        `UWK_ST_UNCONF, `UWK_ST_CONF: begin
          if (I_USB_SET_CONFIG) begin
            configured_q <= 1'b1;
            state_q <= `UWK_ST_CONF;
          end else if (I_USB_CLR_CONFIG) begin
            configured_q <= 1'b0;
            state_q <= `UWK_ST_UNCONF;
          end else if (detach_en_q) begin
            state_q <= `UWK_ST_DETACHED;
          end else if (I_USB_SUSPEND) begin
            state_q <= `UWK_ST_SUSPEND;
          end
        end
        `UWK_ST_SUSPEND: begin
          if (host_resume || wake_req) begin
            state_q <= configured_q ? `UWK_ST_CONF : `UWK_ST_UNCONF;
            // Only with the host feature granted in HS/FS
            O_REMOTE_WAKE <= wake_req & I_REMOTE_WAKE_FEATURE & I_USB_HS_FS;
          end
        end
        `UWK_ST_DETACHED: begin
          if (detach_link_wake || wake_req) begin
            state_q <= `UWK_ST_PLL_UP;
            lock_cnt_q <= 8'h00;
          end
        end
        `UWK_ST_PLL_UP: begin
          // Attach only after PLLs have settled
          if (lock_cnt_q == PLL_LOCK_CYCLES[7:0]) begin
            state_q <= `UWK_ST_UNCONF;
            configured_q <= 1'b0;
          end else begin
            lock_cnt_q <= lock_cnt_q + 8'h01;
          end
        end
        default: state_q <= `UWK_ST_UNPOWERED;
      endcase
    end
  end

  // ==================================================
  // Pin-level outputs
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      O_USB_ATTACH <= 1'b0;
      O_PLL_EN <= 1'b0;
      O_AFE_EN <= 1'b0;
      O_SUSPEND_N <= 1'b1;
      O_PHY_IRQ_EP <= 1'b0;
      O_PME <= 1'b0;
    end else begin
      // Detached keeps only crystal-side logic alive
      O_USB_ATTACH <= (state_q == `UWK_ST_UNCONF) | (state_q == `UWK_ST_CONF)
                      | (state_q == `UWK_ST_SUSPEND);
      O_PLL_EN <= (state_q == `UWK_ST_UNCONF) | (state_q == `UWK_ST_CONF)
                  | (state_q == `UWK_ST_PLL_UP)
                  | ((state_q == `UWK_ST_SUSPEND) & (susp_lvl_q == `UWK_SUSP_ALWAYS_ON));
      O_AFE_EN <= (state_q == `UWK_ST_UNCONF) | (state_q == `UWK_ST_CONF)
                  | (state_q == `UWK_ST_PLL_UP);
      O_SUSPEND_N <= ~((state_q == `UWK_ST_SUSPEND) & ~(wake_req & susp_pin_q));
      O_PHY_IRQ_EP <= irq_q[NPIN];
      O_PME <= pme_mode_q & wake_req;
    end
  end

  // ==================================================
  // Register file; hardware sets win over software clears
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      detach_en_q <= 1'b0;
      detach_ret_q <= 1'b0;
      irq_q <= {(NPIN+1){1'b0}};
      wups0_q <= 1'b0;
      wups1_q <= 1'b0;
      phy_wake_en_q <= 1'b0;
      lan_wake_en_q <= 1'b0;
      susp_lvl_q <= `UWK_SUSP_RESET;
      pme_mode_q <= 1'b0;
      susp_pin_q <= 1'b0;
      pin_en_a_q <= {NPIN{1'b0}};
      pin_en_b_q <= {NPIN{1'b0}};
      pin_wake_en_q <= {NPIN{1'b0}};
      pin_pol_q <= {NPIN{1'b0}};
      cause_q <= 22'h000000;
      wucsr_q <= 5'h00;
    end else begin
      if (wr_hw) begin
        detach_en_q <= I_PWDATA[`UWK_HW_DETACH_EN_BIT];
        if (I_PWDATA[`UWK_HW_DETACH_RET_BIT]) begin
          detach_ret_q <= 1'b0;
        end
      end
      if (state_q == `UWK_ST_DETACHED) begin
        detach_en_q <= 1'b0;
      end
      if (state_q == `UWK_ST_PLL_UP) begin
        detach_ret_q <= 1'b1;
      end
      // Write-one-to-clear, then sets on top
      irq_q <= (irq_q & ~({(NPIN+1){wr_irq}} & I_PWDATA[NPIN:0]))
               | {I_PHY_IRQ, pin_act};
      if (wr_pmt) begin
        phy_wake_en_q <= I_PWDATA[`UWK_PMT_PHY_WAKE_EN_BIT];
        lan_wake_en_q <= I_PWDATA[`UWK_PMT_LAN_WAKE_EN_BIT];
        pme_mode_q <= I_PWDATA[`UWK_PMT_PME_MODE_BIT];
        susp_pin_q <= I_PWDATA[`UWK_PMT_SUSP_PIN_BIT];
        // Unconfigured may only use the deep level
        susp_lvl_q <= configured_q ? I_PWDATA[`UWK_PMT_SUSP_HI:`UWK_PMT_SUSP_LO]
                                   : `UWK_SUSP_DEEP;
      end else if (!configured_q) begin
        susp_lvl_q <= `UWK_SUSP_DEEP;
      end
      // Status stays set while its internal source is still high
      wups0_q <= (wups0_q & ~(wr_pmt & I_PWDATA[`UWK_PMT_WUPS0_BIT])) | src[0];
      // Only frames permitted here, and I_MAC_WAKE, may latch, else one permit would wake on any frame
      wups1_q <= (wups1_q & ~(wr_pmt & I_PWDATA[`UWK_PMT_WUPS1_BIT]))
                 | I_MAC_WAKE | (|(src[8:1] & ok[8:1]));
      if (wr & hit(I_PADDR, `UWK_PIN_CFG_A_OFS)) begin
        pin_en_a_q <= I_PWDATA[NPIN-1:0];
      end
      if (wr & hit(I_PADDR, `UWK_PIN_CFG_B_OFS)) begin
        pin_en_b_q <= I_PWDATA[NPIN-1:0];
      end
      if (wr & hit(I_PADDR, `UWK_PIN_WAKE_OFS)) begin
        pin_wake_en_q <= I_PWDATA[NPIN-1:0];
        pin_pol_q <= I_PWDATA[`UWK_PIN_POL_LO+NPIN-1:`UWK_PIN_POL_LO];
      end
      if (wr & hit(I_PADDR, `UWK_WAKE_CTRL_STATUS_REG_ONE_OFS)) begin
        wucsr_q <= I_PWDATA[4:0];
      end
      // Capture at event time: frame events are pulses, gone by the wake edge
      cause_q <= (cause_q & ~({22{wr_wc}} & I_PWDATA[21:0]))
                 | {host_resume, src[8:1] & ok[8:1] & {8{lan_wake_en_q}},
                    src[0] & ok[0] & phy_wake_en_q,
                    pin_act & {NPIN{ok[9]}}};
    end
  end

  // ==================================================
  // APB slave: one wait state, unmapped reads zero with error
  reg [31:0] rd_d;
  reg err_d;
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (hit(I_PADDR, `UWK_HARDWARE_CONFIG_REG_OFS)) begin
      rd_d[`UWK_HW_DETACH_EN_BIT] = detach_en_q;
      rd_d[`UWK_HW_DETACH_RET_BIT] = detach_ret_q;
    end else if (hit(I_PADDR, `UWK_IRQ_STS_OFS)) begin
      rd_d[NPIN:0] = irq_q;
    end else if (hit(I_PADDR, `UWK_POWER_CONTROL_REG_OFS)) begin
      rd_d[`UWK_PMT_WUPS0_BIT] = wups0_q;
      rd_d[`UWK_PMT_WUPS1_BIT] = wups1_q;
      rd_d[`UWK_PMT_PHY_WAKE_EN_BIT] = phy_wake_en_q;
      rd_d[`UWK_PMT_LAN_WAKE_EN_BIT] = lan_wake_en_q;
      rd_d[`UWK_PMT_SUSP_HI:`UWK_PMT_SUSP_LO] = susp_lvl_q;
      rd_d[`UWK_PMT_PME_MODE_BIT] = pme_mode_q;
      rd_d[`UWK_PMT_SUSP_PIN_BIT] = susp_pin_q;
    end else if (hit(I_PADDR, `UWK_PIN_CFG_A_OFS)) begin
      rd_d[NPIN-1:0] = pin_en_a_q;
    end else if (hit(I_PADDR, `UWK_PIN_CFG_B_OFS)) begin
      rd_d[NPIN-1:0] = pin_en_b_q;
    end else if (hit(I_PADDR, `UWK_PIN_WAKE_OFS)) begin
      rd_d[NPIN-1:0] = pin_wake_en_q;
      rd_d[`UWK_PIN_POL_LO+NPIN-1:`UWK_PIN_POL_LO] = pin_pol_q;
    end else if (hit(I_PADDR, `UWK_WAKE_CAUSE_OFS)) begin
      rd_d[21:0] = cause_q;
    end else if (hit(I_PADDR, `UWK_WAKE_CTRL_STATUS_REG_ONE_OFS)) begin
      rd_d[4:0] = wucsr_q;
    end else if (hit(I_PADDR, `UWK_STATE_OFS)) begin
      rd_d[2:0] = state_q;
    end else begin
      err_d = 1'b1;
    end
  end

  always @(posedge I_CLK) begin
    if (I_SRST) begin
      O_PRDATA <= 32'h00000000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      // Ready one cycle into access phase, lowered after
      O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & err_d;
      O_PRDATA <= (I_PSEL & I_PENABLE & ~O_PREADY & ~I_PWRITE) ? rd_d : 32'h00000000;
    end
  end

endmodule

// [tb/uwk_wake_ctrl_chk.sv]
// Checker for the wake controller: APB timing, wake pulse, reset values.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module uwk_wake_ctrl_chk #(
  parameter NPIN = 12,
  parameter PLL_LOCK_CYCLES = 16
) (
  input wire I_CLK,
  input wire I_SRST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire I_REMOTE_WAKE_FEATURE,
  input wire I_USB_HS_FS,
  input wire I_PHY_IRQ,
  input wire O_USB_ATTACH,
  input wire O_PLL_EN,
  input wire O_AFE_EN,
  input wire O_REMOTE_WAKE,
  input wire O_SUSPEND_N,
  input wire O_PHY_IRQ_EP
);
  // =======
  // Properties
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence s_access;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  sequence s_answer;
    O_PREADY ##1 !O_PREADY;
  endsequence
  property p_apb_answer;
    s_access |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("ready not one cycle late");
  property p_err_ready;
    O_PSLVERR |-> O_PREADY && I_PSEL && I_PENABLE;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside answer");
  property p_rdata_idle;
    !O_PREADY |-> O_PRDATA == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_phy_ep;
    I_PHY_IRQ |-> ##[1:2] O_PHY_IRQ_EP;
  endproperty
  a_phy_ep: assert property (p_phy_ep) else $error("phy irq not flagged");
  property p_rw_feature;
    O_REMOTE_WAKE |-> I_REMOTE_WAKE_FEATURE && I_USB_HS_FS;
  endproperty
  a_rw_feature: assert property (p_rw_feature) else $error("remote wake unarmed");
  property p_rw_pulse;
    O_REMOTE_WAKE |=> !O_REMOTE_WAKE;
  endproperty
  a_rw_pulse: assert property (p_rw_pulse) else $error("remote wake too long");
  property p_attach_pll;
    $rose(O_USB_ATTACH) |-> O_PLL_EN && O_AFE_EN;
  endproperty
  a_attach_pll: assert property (p_attach_pll) else $error("attach before pll");
  property p_detach_pll;
    $fell(O_USB_ATTACH) |-> !O_PLL_EN;
  endproperty
  a_detach_pll: assert property (p_detach_pll) else $error("pll on after detach");
  property p_reset_out;
    $fell(I_SRST) |-> !O_USB_ATTACH && O_SUSPEND_N && !O_REMOTE_WAKE;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not at reset");
endmodule

bind uwk_wake_ctrl uwk_wake_ctrl_chk #(.NPIN(NPIN), .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_chk (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_REMOTE_WAKE_FEATURE(I_REMOTE_WAKE_FEATURE), .I_USB_HS_FS(I_USB_HS_FS),
  .I_PHY_IRQ(I_PHY_IRQ), .O_USB_ATTACH(O_USB_ATTACH), .O_PLL_EN(O_PLL_EN),
  .O_AFE_EN(O_AFE_EN), .O_REMOTE_WAKE(O_REMOTE_WAKE), .O_SUSPEND_N(O_SUSPEND_N),
  .O_PHY_IRQ_EP(O_PHY_IRQ_EP));

// [tb/uwk_usb_host.sv]
// USB host model: reset, suspend, resume and configuration requests.
// Assumes cmd is called right after a rising clock edge.
`timescale 1ns/1ps
module uwk_usb_host (
  input wire i_clk,
  input wire i_remote_wake,
  output wire o_usb_reset,
  output wire o_suspend,
  output wire o_resume,
  output wire o_set_config,
  output wire o_clr_config,
  output wire o_feature,
  output wire o_hs_fs
);
  // =======
  // Requests
  reg [4:0] req_q = 5'h00;
  integer wakes = 0;
  assign o_usb_reset = req_q[0];
  assign o_suspend = req_q[1];
  assign o_resume = req_q[2];
  assign o_set_config = req_q[3];
  assign o_clr_config = req_q[4];
  // Link held high speed; remote wakeup feature set unless the bench revokes it
  reg feat_q = 1'b1;
  assign o_feature = feat_q;
  assign o_hs_fs = 1'b1;
  // One-cycle pulses so no request lingers into the next state
  task cmd(input integer k);
    begin
      req_q[k] <= 1'b1;
      @(posedge i_clk);
      req_q <= 5'h00;
    end
  endtask
  always @(posedge i_clk) begin
    if (i_remote_wake === 1'b1)
      wakes <= wakes + 1;
  end
endmodule

// [tb/tb.sv]
// Testbench for the wake controller: APB master, pins, MAC events, host model.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`include "uwk_defines.vh"
module tb;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg [11:0] pa = 12'h000;
  reg [31:0] pd = 32'h00000000;
  reg [11:0] gpio = 12'h000;
  reg [8:0] ev = 9'h000;
  reg link = 1'b0;
  reg mac = 1'b0;
  reg vbus = 1'b0;
  reg pme = 1'b0;
  reg [31:0] seed = 32'h7203989B;
  reg [31:0] r;
  reg e;
  wire [31:0] prd;
  wire prdy, perr, ur, us, ures, sc, cc, ft, hs, att, pll, rw;
  wire afe, sn, ep, pmo;
  integer fails = 0;
  integer check_count = 0;
  integer i;
  integer w0;
  integer pm = 0;
  integer pm0;
  uwk_wake_ctrl #(.PLL_LOCK_CYCLES(2)) DUT (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prd),
    .O_PREADY(prdy), .O_PSLVERR(perr), .I_GPIO(gpio), .I_BUS_POWER_SENSE(vbus),
    .I_USB_RESET(ur), .I_USB_SUSPEND(us), .I_USB_RESUME(ures), .I_USB_SET_CONFIG(sc),
    .I_USB_CLR_CONFIG(cc), .I_REMOTE_WAKE_FEATURE(ft), .I_USB_HS_FS(hs), .I_PHY_IRQ(ev[0]),
    .I_LINK_UP(link), .I_MAC_WAKE(mac), .I_MAGIC_PKT(ev[1]), .I_WAKE_FRAME(ev[2]),
    .I_BCAST_FRAME(ev[3]), .I_EXACT_FRAME(ev[4]), .I_TCP_SYN(ev[5]), .I_EEE_RX_WAKE(ev[6]),
    .I_EEE_TX_WAKE(ev[7]), .I_GOOD_FRAME(ev[8]), .O_USB_ATTACH(att), .O_PLL_EN(pll),
    .O_AFE_EN(afe), .O_REMOTE_WAKE(rw), .O_SUSPEND_N(sn), .O_PHY_IRQ_EP(ep), .O_PME(pmo));
  uwk_usb_host u_host (.i_clk(clk), .i_remote_wake(rw), .o_usb_reset(ur), .o_suspend(us),
    .o_resume(ures), .o_set_config(sc), .o_clr_config(cc), .o_feature(ft), .o_hs_fs(hs));
  always #2.5 clk = ~clk;
  // Counts event-pin high cycles so each trial can check for one pulse or none
  always @(posedge clk) begin
    if (pmo === 1'b1)
      pm <= pm + 1;
  end
  // =======
  // Helpers
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [1:0] lvl(input integer n);
    lvl = (n % 3 == 0) ? `UWK_SUSP_SHALLOW : (n % 3 == 1) ? `UWK_SUSP_DEEP : `UWK_SUSP_ALWAYS_ON;
  endfunction
  // Good frame only in always-on; deep takes no network source
  function permit(input [1:0] l, input integer k);
    permit = (l == `UWK_SUSP_ALWAYS_ON) || (l == `UWK_SUSP_SHALLOW && k < 8);
  endfunction
  task complete_run;
    begin
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [63:0] n, input [31:0] x, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("[ERR] %0s expected %h seen %h", n, x, g);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Wait for ready, then check it took one cycle; only the watchdog ends a hang
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (prdy !== 1'b1) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("ready", 32'h1, n);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] x, input [63:0] n);
    begin
      apb(1'b0, a, 32'h0);
      chk(n, x, r & m);
    end
  endtask
  // k 0..8 network event, 16 pin wake, 17 pin with function disabled
  task trial(input [1:0] l, input integer k, input [4:0] u, input x);
    reg pol;
    reg [3:0] p;
    reg [31:0] b;
    reg [31:0] c;
    begin
      seed = lfsr(seed);
      pol = seed[0];
      p = seed[7:4] % 12;
      b = 32'h1 << p;
      c = (k < 9) ? 32'h1000 << k : b;
      gpio <= {12{~pol}};
      apb(1'b1, `UWK_PIN_CFG_A_OFS, (k == 16 && !seed[8]) ? b : 32'h0);
      apb(1'b1, `UWK_PIN_CFG_B_OFS, (k == 16 && seed[8]) ? b : 32'h0);
      apb(1'b1, `UWK_PIN_WAKE_OFS, (k > 15) ? b | ({31'h0, pol} << (16 + p)) : 32'h0);
      apb(1'b1, `UWK_WAKE_CTRL_STATUS_REG_ONE_OFS, {27'h0, u});
      apb(1'b1, `UWK_POWER_CONTROL_REG_OFS, 32'hF | {24'h0, 1'b0, pme, l, 4'h0});
      apb(1'b1, `UWK_WAKE_CAUSE_OFS, 32'hFFFFFFFF);
      apb(1'b1, `UWK_IRQ_STS_OFS, 32'hFFFFFFFF);
      w0 = u_host.wakes;
      pm0 = pm;
      u_host.cmd(1);
      wt(3);
      rd(`UWK_STATE_OFS, 32'h7, 32'h3, "susp");
      chk("suspn", 32'h0, {31'h0, sn});
      if (k < 9) begin
        ev[k] <= 1'b1;
        wt(1);
        ev <= 9'h000;
      end else
        gpio[p] <= pol;
      wt(6);
      rd(`UWK_STATE_OFS, 32'h7, x ? 32'h2 : 32'h3, "wake");
      chk("suspn", {31'h0, x}, {31'h0, sn});
      chk("phyep", {31'h0, k == 0}, {31'h0, ep});
      chk("pme", {31'h0, x & pme}, pm - pm0);
      if (x) begin
        rd(`UWK_WAKE_CAUSE_OFS, c, c, "cause");
        if (k > 15)
          rd(`UWK_IRQ_STS_OFS, b, b, "pinirq");
      end else begin
        u_host.cmd(2);
        wt(4);
        rd(`UWK_STATE_OFS, 32'h7, 32'h2, "resume");
      end
      chk("rwake", {31'h0, x & u_host.feat_q}, u_host.wakes - w0);
      gpio <= {12{~pol}};
      wt(3);
    end
  endtask
  // =======
  // Sequence
  initial begin
    #250000;
    fails = fails + 1;
    complete_run;
  end
  initial begin
    wt(6);
    srst <= 1'b0;
    wt(5);
    rd(`UWK_STATE_OFS, 32'hFFFFFFFF, 32'h0, "unpwr");
    vbus <= 1'b1;
    wt(5);
    rd(`UWK_STATE_OFS, 32'hFFFFFFFF, 32'h1, "state");
    rd(`UWK_POWER_CONTROL_REG_OFS, 32'hFFFFFFFF, 32'h20, "pmt");
    apb(1'b0, 12'hFFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, `UWK_POWER_CONTROL_REG_OFS, 32'h0);
    rd(`UWK_POWER_CONTROL_REG_OFS, 32'h30, 32'h20, "level");
    u_host.cmd(1);
    wt(3);
    u_host.cmd(2);
    wt(4);
    rd(`UWK_STATE_OFS, 32'h7, 32'h1, "unconf");
    u_host.cmd(3);
    wt(3);
    for (i = 0; i < 27; i = i + 1)
      trial(lvl(i / 9), i % 9, 5'h1F, permit(lvl(i / 9), i % 9));
    trial(`UWK_SUSP_SHALLOW, 3, 5'h00, 1'b0);
    trial(`UWK_SUSP_SHALLOW, 4, 5'h00, 1'b0);
    // Event-pin mode: phy and the four frame kinds wake, the rest do not
    pme = 1'b1;
    for (i = 0; i < 9; i = i + 1)
      trial(`UWK_SUSP_SHALLOW, i, 5'h1F, i < 5);
    pme = 1'b0;
    for (i = 0; i < 6; i = i + 1)
      trial(lvl(i), i < 4 ? 16 : 17, 5'h1F, i < 4);
    u_host.feat_q <= 1'b0;
    trial(`UWK_SUSP_SHALLOW, 16, 5'h1F, 1'b1);
    u_host.feat_q <= 1'b1;
    mac <= 1'b1;
    wt(3);
    apb(1'b1, `UWK_POWER_CONTROL_REG_OFS, 32'hA);
    rd(`UWK_POWER_CONTROL_REG_OFS, 32'h2, 32'h2, "wups1");
    mac <= 1'b0;
    wt(2);
    apb(1'b1, `UWK_POWER_CONTROL_REG_OFS, 32'h2);
    rd(`UWK_POWER_CONTROL_REG_OFS, 32'h2, 32'h0, "wups1");
    u_host.cmd(1);
    wt(3);
    u_host.cmd(0);
    wt(8);
    rd(`UWK_STATE_OFS, 32'h7, 32'h1, "usbrst");
    u_host.cmd(3);
    wt(3);
    apb(1'b1, `UWK_POWER_CONTROL_REG_OFS, 32'h5);
    apb(1'b1, `UWK_HARDWARE_CONFIG_REG_OFS, 32'h1);
    wt(3);
    chk("attpll", 32'h0, {29'h0, att, pll, afe});
    rd(`UWK_STATE_OFS, 32'h7, 32'h4, "detach");
    ev[1] <= 1'b1;
    wt(1);
    ev <= 9'h000;
    wt(4);
    rd(`UWK_STATE_OFS, 32'h7, 32'h4, "detach");
    link <= 1'b1;
    for (i = 0; i < 60 && att !== 1'b1; i = i + 1)
      wt(1);
    link <= 1'b0;
    chk("attach", 32'h7, {29'h0, att, pll, afe});
    rd(`UWK_HARDWARE_CONFIG_REG_OFS, 32'h2, 32'h2, "retflag");
    rd(`UWK_STATE_OFS, 32'h7, 32'h1, "reatt");
    complete_run;
  end
endmodule
